// >>> rtl/nonpriv_gate_consts.vh
// Constants shared by the privilege gate and its global state memory.
`ifndef NONPRIV_GATE_CONSTS_VH
`define NONPRIV_GATE_CONSTS_VH

`define ADDR_W            21
`define IDX_W             4
`define GS_DEPTH          16

// Engine kinds on engineKind.
`define ENG_RENDER        3'h0
`define ENG_POSITION      3'h1
`define ENG_COMPUTE       3'h2
`define ENG_BLITTER       3'h3
`define ENG_VIDEO         3'h4
`define ENG_ENHANCE       3'h5

// Command classes on cmdClass.
`define CMD_OTHER         3'h0
`define CMD_COND_END      3'h1
`define CMD_PRIV_ALWAYS   3'h2
`define CMD_PRIV_GLOBAL   3'h3
`define CMD_LOAD_REG_IMM  3'h4

// Streamer and unit bases.
`define VIDEO_BASE0       21'h1c0000
`define VIDEO_ODD_STEP    21'h004000
`define VIDEO_PAIR_STEP   21'h010000
`define ENH_BASE0         21'h1c8000
`define ENH_STEP          21'h010000
`define CODEC_UNIT_A      21'h002800
`define CODEC_UNIT_B      21'h002d00

// Allow-list starts and sizes in dwords.
`define RND_GPR           21'h002600
`define POS_GPR           21'h018600
`define CMP_GPR           21'h01a600
`define BLT_GPR           21'h022600
`define GPR_DW            10'd32
`define STAT_FIRST        21'h002300
`define STAT_DW           10'd22
`define POS_STAT_A        21'h018310
`define POS_STAT_A_DW     10'd6
`define POS_STAT_B        21'h018338
`define POS_STAT_B_DW     10'd4
`define RND_AUX           21'h004200
`define RND_TRTT          21'h004400
`define CMP_AUX           21'h0042c0
`define CMP_TRTT          21'h004580
`define BLT_TRTT          21'h004480
`define ENH_AUX           21'h0042b0
`define ENH_TRTT          21'h004560
`define ENH_TRTT_INV      21'h004474
`define VID1_AUX          21'h004290
`define VID1_TRTT         21'h004520
`define VID2_AUX          21'h0042a0
`define VID2_TRTT         21'h004540
`define AUX_DW            10'd3
`define TRTT_DW           10'd6
`define ENH_TRTT_DW       10'd5
`define REL_GPR           21'h000600
`define REL_CODEC         21'h000800
`define CODEC_DW          10'd512
`define UNIT_DW           10'd64
`define REL_PERF_CTL      21'h000178
`define REL_NOPID         21'h000094
`define REL_PRED_RES1     21'h00041c
`define REL_PRED_RES2     21'h0003bc
`define REL_INSTPM        21'h0000c0

`endif

// >>> rtl/global_state_ram.v
// Single-copy global state store with one write port and a registered read.
`default_nettype none
`include "nonpriv_gate_consts.vh"

module global_state_ram #(
    parameter DEPTH = `GS_DEPTH,
    parameter IDX_W = `IDX_W,
    parameter DW    = 32
) (
    input  wire             sys_clk,
    input  wire             wrEn,
    input  wire [IDX_W-1:0] wrIdx,
    input  wire [DW-1:0]    wrData,
    input  wire [IDX_W-1:0] rdIdx,
    output reg  [DW-1:0]    rdData_q
);

    reg [DW-1:0] mem [0:DEPTH-1];

    always @(posedge sys_clk)
    begin
        if (wrEn)
        begin
            mem[wrIdx] <= wrData;
        end
        rdData_q <= mem[rdIdx];
    end

endmodule

`default_nettype wire

// >>> rtl/nonpriv_batch_register_gate.v
// Privilege gate for commands and register accesses from non-privileged batches.
`default_nettype none
`include "nonpriv_gate_consts.vh"

module nonpriv_batch_register_gate #(
    parameter DESC_W = 32,
    parameter DW     = 32
) (
    input  wire               sys_clk,
    input  wire               srst,
    input  wire [2:0]         engineKind,
    input  wire [2:0]         engineInst,
    input  wire               privCheckDisable,
    input  wire               batchActive,
    input  wire               batchInGlobalSpace,
    input  wire               cmdValid,
    input  wire [2:0]         cmdClass,
    input  wire               cmdUsesGlobal,
    input  wire [`ADDR_W-1:0] cmdRegAddr,
    input  wire               regValid,
    input  wire               regWrite,
    input  wire [`ADDR_W-1:0] regAddr,
    input  wire               roReadAllowed,
    input  wire               errClear,
    input  wire               ctxSubmitValid,
    input  wire [DESC_W-1:0]  ctxDescAddr,
    input  wire               ctxLoadDone,
    input  wire               ctxDone,
    input  wire               gsWrValid,
    input  wire [`IDX_W-1:0]  gsWrIdx,
    input  wire [DW-1:0]      gsWrData,
    input  wire [`IDX_W-1:0]  gsRdIdx,
    input  wire               pwrDownReq,
    input  wire               pwrUpReq,
    input  wire               restoreValid,
    input  wire [DW-1:0]      restoreData,
    output reg                cmdOutValid_q,
    output reg                cmdNoop_q,
    output reg                parserViolationIrq_q,
    output reg                errCmdPriv_q,
    output reg                regGrant_q,
    output reg                regDeny_q,
    output reg                ctxReady_q,
    output reg                ctxLoadReq_q,
    output reg  [DESC_W-1:0]  ctxLoadAddr_q,
    output reg                ctxRunning_q,
    output wire [DW-1:0]      gsRdData,
    output reg                saveValid_q,
    output reg  [`IDX_W-1:0]  saveIdx_q,
    output wire [DW-1:0]      saveData,
    output reg                pwrOff_q,
    output reg                restoreReq_q,
    output reg  [`IDX_W-1:0]  restoreIdx_q
);

    localparam [2:0] CTX_IDLE = 3'b001;
    localparam [2:0] CTX_LOAD = 3'b010;
    localparam [2:0] CTX_RUN  = 3'b100;

    localparam [3:0] PWR_ON      = 4'b0001;
    localparam [3:0] PWR_SAVE    = 4'b0010;
    localparam [3:0] PWR_OFF     = 4'b0100;
    localparam [3:0] PWR_RESTORE = 4'b1000;

    localparam integer      LAST_I   = `GS_DEPTH - 1;
    localparam [`IDX_W-1:0] LAST_IDX = LAST_I[`IDX_W-1:0];

    // Entry covers start .. start+4N-4 on dword boundaries only.
    function inRange;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] start;
        input [9:0]         nDw;
        reg   [`ADDR_W-1:0] last;
        begin
            last    = start + {{(`ADDR_W-12){1'b0}}, nDw, 2'b00} - `ADDR_W'd4;
            inRange = (a[1:0] == 2'b00) && (a >= start) && (a <= last);
        end
    endfunction

    function [`ADDR_W-1:0] engineBase;
        input [2:0] kind;
        input [2:0] inst;
        begin
            if (kind == `ENG_VIDEO)
            begin
                engineBase = `VIDEO_BASE0 + (inst[0] ? `VIDEO_ODD_STEP : `ADDR_W'd0)
                           + `VIDEO_PAIR_STEP * {{(`ADDR_W-2){1'b0}}, inst[2:1]};
            end
            else
            begin
                engineBase = `ENH_BASE0 + `ENH_STEP * {{(`ADDR_W-3){1'b0}}, inst};
            end
        end
    endfunction

    // Registers shared by every video and enhancement streamer, relative to its base.
    function relCommon;
        input [`ADDR_W-1:0] r;
        begin
            relCommon = inRange(r, `REL_GPR, `GPR_DW)
                      | inRange(r, `REL_PERF_CTL, 10'd2)
                      | inRange(r, `REL_NOPID, 10'd1)
                      | inRange(r, `REL_PRED_RES1, 10'd1)
                      | inRange(r, `REL_PRED_RES2, 10'd1)
                      | inRange(r, `REL_INSTPM, 10'd1);
        end
    endfunction

    function writeListed;
        input [2:0]         kind;
        input [2:0]         inst;
        input [`ADDR_W-1:0] a;
        reg   [`ADDR_W-1:0] rel;
        begin
            rel = a - engineBase(kind, inst);
            case (kind)
                `ENG_RENDER:
                    writeListed = inRange(a, `RND_GPR, `GPR_DW)
                                | inRange(a, `STAT_FIRST, `STAT_DW)
                                | inRange(a, `RND_AUX, `AUX_DW)
                                | inRange(a, `RND_TRTT, `TRTT_DW);
                `ENG_POSITION:
                    writeListed = inRange(a, `POS_GPR, `GPR_DW)
                                | inRange(a, `POS_STAT_A, `POS_STAT_A_DW)
                                | inRange(a, `POS_STAT_B, `POS_STAT_B_DW);
                `ENG_COMPUTE:
                    writeListed = inRange(a, `CMP_GPR, `GPR_DW)
                                | inRange(a, `CMP_AUX, `AUX_DW)
                                | inRange(a, `CMP_TRTT, `TRTT_DW);
                `ENG_BLITTER:
                    writeListed = inRange(a, `BLT_GPR, `GPR_DW)
                                | inRange(a, `BLT_TRTT, `TRTT_DW);
                `ENG_VIDEO:
                    writeListed = relCommon(rel)
                                | inRange(rel, `REL_CODEC, `CODEC_DW)
                                | inRange(rel, `CODEC_UNIT_A, `UNIT_DW)
                                | inRange(rel, `CODEC_UNIT_B, `UNIT_DW)
                                | ((inst == 3'd1) && (inRange(a, `VID1_AUX, `AUX_DW)
                                    | inRange(a, `VID1_TRTT, `TRTT_DW)))
                                | ((inst == 3'd2) && (inRange(a, `VID2_AUX, `AUX_DW)
                                    | inRange(a, `VID2_TRTT, `TRTT_DW)));
                `ENG_ENHANCE:
                    writeListed = relCommon(rel)
                                | ((inst == 3'd0) && (inRange(a, `ENH_AUX, `AUX_DW)
                                    | inRange(a, `ENH_TRTT, `ENH_TRTT_DW)
                                    | inRange(a, `ENH_TRTT_INV, 10'd1)));
                default:
                    writeListed = 1'b0;
            endcase
        end
    endfunction

    // Checking applies only to per-process batches and only while enabled.
    wire nonPriv = batchActive && !batchInGlobalSpace && !privCheckDisable;

    reg cmdDrop;
    always @*
    begin
        cmdDrop = 1'b0;
        if (nonPriv)
        begin
            case (cmdClass)
                `CMD_COND_END:     cmdDrop = cmdUsesGlobal;
                `CMD_PRIV_ALWAYS:  cmdDrop = 1'b1;
                `CMD_PRIV_GLOBAL:  cmdDrop = cmdUsesGlobal;
                `CMD_LOAD_REG_IMM:
                    cmdDrop = !writeListed(engineKind, engineInst, cmdRegAddr);
                default:           cmdDrop = 1'b0;
            endcase
        end
    end

    wire violation = cmdValid && cmdDrop;
    wire regOk     = !nonPriv || writeListed(engineKind, engineInst, regAddr)
                   || (!regWrite && roReadAllowed);

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            cmdOutValid_q        <= 1'b0;
            cmdNoop_q            <= 1'b0;
            parserViolationIrq_q <= 1'b0;
            errCmdPriv_q         <= 1'b0;
            regGrant_q           <= 1'b0;
            regDeny_q            <= 1'b0;
        end
        else
        begin
            cmdOutValid_q        <= cmdValid;
            cmdNoop_q            <= violation;
            parserViolationIrq_q <= violation;
            // A new violation in the clearing cycle keeps the bit set.
            errCmdPriv_q         <= violation | (errCmdPriv_q & ~errClear);
            regGrant_q           <= regValid && regOk;
            regDeny_q            <= regValid && !regOk;
        end
    end

    // Context sequencing: a new submission is taken only when idle.
    reg [2:0] ctxState_q;
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctxState_q    <= CTX_IDLE;
            ctxReady_q    <= 1'b1;
            ctxLoadReq_q  <= 1'b0;
            ctxLoadAddr_q <= {DESC_W{1'b0}};
            ctxRunning_q  <= 1'b0;
        end
        else
        begin
            case (ctxState_q)
                CTX_IDLE:
                    if (ctxSubmitValid)
                    begin
                        ctxState_q    <= CTX_LOAD;
                        ctxReady_q    <= 1'b0;
                        ctxLoadReq_q  <= 1'b1;
                        ctxLoadAddr_q <= ctxDescAddr;
                    end
                CTX_LOAD:
                    if (ctxLoadDone)
                    begin
                        ctxState_q   <= CTX_RUN;
                        ctxLoadReq_q <= 1'b0;
                        ctxRunning_q <= 1'b1;
                    end
                CTX_RUN:
                    if (ctxDone)
                    begin
                        ctxState_q   <= CTX_IDLE;
                        ctxRunning_q <= 1'b0;
                        ctxReady_q   <= 1'b1;
                    end
                default:
                begin
                    ctxState_q   <= CTX_IDLE;
                    ctxReady_q   <= 1'b1;
                    ctxLoadReq_q <= 1'b0;
                    ctxRunning_q <= 1'b0;
                end
            endcase
        end
    end

    // Global state power sequencing. The save stream has no back-pressure, so the
    // consumer must take one word per cycle.
    reg [3:0]        pwrState_q;
    reg [`IDX_W-1:0] saveCnt_q;
    reg              saveLast_q;

    wire             onState  = (pwrState_q == PWR_ON);
    wire             saving   = (pwrState_q == PWR_SAVE);
    wire             restWr   = restoreReq_q && restoreValid;
    wire             ramWrEn  = (onState && gsWrValid) || restWr;
    wire [`IDX_W-1:0] ramWrIdx = restWr ? restoreIdx_q : gsWrIdx;
    wire [DW-1:0]    ramWrDat = restWr ? restoreData : gsWrData;
    wire [`IDX_W-1:0] ramRdIdx = saving ? saveCnt_q : gsRdIdx;

    global_state_ram #(
        .DEPTH (`GS_DEPTH),
        .IDX_W (`IDX_W),
        .DW    (DW)
    ) u_state (
        .sys_clk  (sys_clk),
        .wrEn     (ramWrEn),
        .wrIdx    (ramWrIdx),
        .wrData   (ramWrDat),
        .rdIdx    (ramRdIdx),
        .rdData_q (gsRdData)
    );

    assign saveData = gsRdData;

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            pwrState_q   <= PWR_ON;
            saveCnt_q    <= {`IDX_W{1'b0}};
            saveLast_q   <= 1'b0;
            saveValid_q  <= 1'b0;
            saveIdx_q    <= {`IDX_W{1'b0}};
            pwrOff_q     <= 1'b0;
            restoreReq_q <= 1'b0;
            restoreIdx_q <= {`IDX_W{1'b0}};
        end
        else
        begin
            saveValid_q <= saving;
            saveIdx_q   <= saveCnt_q;
            case (pwrState_q)
                PWR_ON:
                    if (pwrDownReq)
                    begin
                        pwrState_q <= PWR_SAVE;
                        saveCnt_q  <= {`IDX_W{1'b0}};
                    end
                PWR_SAVE:
                begin
                    saveCnt_q <= saveCnt_q + `IDX_W'd1;
                    if (saveCnt_q == LAST_IDX)
                    begin
                        pwrState_q <= PWR_OFF;
                        saveLast_q <= 1'b1;
                    end
                end
                PWR_OFF:
                begin
                    // Off is reported only after the last saved word has left.
                    saveLast_q <= 1'b0;
                    pwrOff_q   <= 1'b1;
                    if (pwrUpReq && !saveLast_q)
                    begin
                        pwrState_q   <= PWR_RESTORE;
                        restoreReq_q <= 1'b1;
                        restoreIdx_q <= {`IDX_W{1'b0}};
                    end
                end
                PWR_RESTORE:
                    if (restoreValid)
                    begin
                        restoreIdx_q <= restoreIdx_q + `IDX_W'd1;
                        if (restoreIdx_q == LAST_IDX)
                        begin
                            pwrState_q   <= PWR_ON;
                            restoreReq_q <= 1'b0;
                            pwrOff_q     <= 1'b0;
                        end
                    end
                default:
                begin
                    pwrState_q   <= PWR_ON;
                    pwrOff_q     <= 1'b0;
                    restoreReq_q <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> testbench/nonpriv_gate_properties.sv
// Assertion checker for the privilege gate ports.
`default_nettype none
`include "nonpriv_gate_consts.vh"
module nonpriv_gate_properties (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [2:0]  engineKind,
    input wire logic        privCheckDisable,
    input wire logic        batchActive,
    input wire logic        batchInGlobalSpace,
    input wire logic        cmdValid,
    input wire logic [2:0]  cmdClass,
    input wire logic        cmdUsesGlobal,
    input wire logic        regValid,
    input wire logic [20:0] regAddr,
    input wire logic        errClear,
    input wire logic        cmdOutValid_q,
    input wire logic        cmdNoop_q,
    input wire logic        parserViolationIrq_q,
    input wire logic        errCmdPriv_q,
    input wire logic        regGrant_q,
    input wire logic        regDeny_q,
    input wire logic        ctxReady_q,
    input wire logic        ctxLoadReq_q,
    input wire logic        ctxRunning_q,
    input wire logic        saveValid_q,
    input wire logic        pwrOff_q
);
    timeunit 1ns;
    timeprecision 1ps;
    wire userBatch = batchActive && !batchInGlobalSpace && !privCheckDisable;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    cond_end_a: assert property (
        cmdValid && userBatch && cmdClass == `CMD_COND_END |=> cmdNoop_q == $past(cmdUsesGlobal))
        else $error("conditional end drop wrong");
    priv_drop_a: assert property (
        cmdValid && userBatch && cmdClass == `CMD_PRIV_ALWAYS |=> cmdOutValid_q && cmdNoop_q)
        else $error("privileged command not dropped");
    viol_pair_a: assert property (
        cmdNoop_q || parserViolationIrq_q |-> cmdNoop_q && parserViolationIrq_q && errCmdPriv_q)
        else $error("violation outputs disagree");
    err_sticky_a: assert property (errCmdPriv_q && !errClear |=> errCmdPriv_q)
        else $error("error flag lost");
    check_off_a: assert property (cmdValid && privCheckDisable |=> !cmdNoop_q)
        else $error("command dropped with checks off");
    reg_answer_a: assert property (
        1'b1 |=> (regGrant_q || regDeny_q) == $past(regValid) && !(regGrant_q && regDeny_q))
        else $error("register answer wrong");
    render_gpr_a: assert property (
        regValid && engineKind == `ENG_RENDER && regAddr[20:7] == 14'h004c
        && regAddr[1:0] == 2'h0 |=> regGrant_q) else $error("render register block denied");
    one_ctx_a: assert property (ctxRunning_q |-> !ctxReady_q && !ctxLoadReq_q)
        else $error("context overlap");
    save_span_a: assert property (
        $rose(saveValid_q) |-> saveValid_q[*8] ##1 saveValid_q[*8] ##1 $rose(pwrOff_q))
        else $error("save sequence length wrong");
endmodule
`default_nettype wire

// >>> testbench/gate_memory_model.sv
// Memory-side model: answers context loads and holds the power-save image.
`default_nettype none
module gate_memory_model (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        slow,
    input  wire logic        ctxLoadReq_q,
    output var  logic        ctxLoadDone,
    input  wire logic        saveValid_q,
    input  wire logic [3:0]  saveIdx_q,
    input  wire logic [31:0] saveData,
    input  wire logic        restoreReq_q,
    input  wire logic [3:0]  restoreIdx_q,
    output wire logic        restoreValid,
    output wire logic [31:0] restoreData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] image [16];
    logic [2:0]  waitCnt_q;
    logic        phase_q;
    // A slow memory leaves gaps between restore words.
    assign restoreValid = restoreReq_q && (!slow || phase_q);
    // Between words the bus shows the inverse, never a stale copy.
    assign restoreData = restoreValid ? image[restoreIdx_q] : ~image[restoreIdx_q];
    always @(posedge sys_clk)
    begin
        phase_q <= srst ? 1'b0 : ~phase_q;
        if (saveValid_q)
            image[saveIdx_q] <= saveData;
        if (srst || !ctxLoadReq_q || ctxLoadDone)
        begin
            waitCnt_q <= 3'h0;
            ctxLoadDone <= 1'b0;
        end
        else if (waitCnt_q == (slow ? 3'h5 : 3'h0))
            ctxLoadDone <= 1'b1;
        else
            waitCnt_q <= waitCnt_q + 3'h1;
    end
endmodule
`default_nettype wire

// >>> testbench/nonpriv_batch_register_gate_bench.sv
// Self-checking bench for the privilege gate.
`default_nettype none
module nonpriv_batch_register_gate_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, srst = 1'b1, slow = 1'b0, batchActive = 1'b1;
    logic [2:0]  engineKind = 3'h0, engineInst = 3'h0, cmdClass = 3'h0;
    logic        privCheckDisable = 1'b0, batchInGlobalSpace = 1'b0, cmdValid = 1'b0;
    logic        cmdUsesGlobal = 1'b0, regValid = 1'b0, regWrite = 1'b0;
    logic        roReadAllowed = 1'b0, errClear = 1'b0, ctxSubmitValid = 1'b0;
    logic        ctxDone = 1'b0, gsWrValid = 1'b0, pwrDownReq = 1'b0, pwrUpReq = 1'b0;
    logic [20:0] cmdRegAddr = 21'h0, regAddr = 21'h0;
    logic [31:0] ctxDescAddr = 32'h0, gsWrData = 32'h0;
    logic [3:0]  gsWrIdx = 4'h0, gsRdIdx = 4'h0;
    wire         ctxLoadDone, restoreValid, cmdOutValid_q, cmdNoop_q, errCmdPriv_q;
    wire         parserViolationIrq_q, regGrant_q, regDeny_q, ctxReady_q, ctxLoadReq_q;
    wire         ctxRunning_q, saveValid_q, pwrOff_q, restoreReq_q;
    wire [31:0]  restoreData, ctxLoadAddr_q, gsRdData, saveData;
    wire [3:0]   saveIdx_q, restoreIdx_q;
    int          mismatches = 0, compares = 0, cycles = 0;

    nonpriv_batch_register_gate u_nonpriv_batch_register_gate (.*);
    gate_memory_model u_gate_memory_model (.*);

    initial forever #4 sys_clk = ~sys_clk;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic send_cmd(input logic [2:0] c, input logic g, input logic [20:0] a,
                            input logic drop);
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdClass <= c;
        cmdUsesGlobal <= g;
        cmdRegAddr <= a;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        #1;
        chk("cmdOutValid", cmdOutValid_q, 32'h1);
        chk("cmdNoop", cmdNoop_q, drop);
        chk("violationIrq", parserViolationIrq_q, drop);
    endtask

    task automatic test_cmds();
        for (int c = 0; c < 5; c++)
            for (int g = 0; g < 2; g++)
                send_cmd(c[2:0], g[0], 21'h000100, c == 2 || c == 4 || (c != 0 && g == 1));
        send_cmd(3'h4, 1'b0, 21'h002600, 1'b0);
        chk("errFlag", errCmdPriv_q, 32'h1);
        // The clear stands through the violation cycle, where the set must win.
        errClear <= 1'b1;
        send_cmd(3'h2, 1'b0, 21'h000100, 1'b1);
        chk("errFlag", errCmdPriv_q, 32'h1);
        @(posedge sys_clk);
        errClear <= 1'b1;
        batchInGlobalSpace <= 1'b1;
        @(posedge sys_clk);
        errClear <= 1'b0;
        #1;
        chk("errFlag", errCmdPriv_q, 32'h0);
        send_cmd(3'h2, 1'b1, 21'h000100, 1'b0);
        @(posedge sys_clk);
        batchInGlobalSpace <= 1'b0;
        privCheckDisable <= 1'b1;
        send_cmd(3'h2, 1'b1, 21'h000100, 1'b0);
        @(posedge sys_clk);
        privCheckDisable <= 1'b0;
    endtask

    task automatic reg_case(input logic [2:0] k, input logic [2:0] i, input logic w,
                            input logic ro, input logic [20:0] a, input logic ok);
        @(posedge sys_clk);
        engineKind <= k;
        engineInst <= i;
        regValid <= 1'b1;
        regWrite <= w;
        roReadAllowed <= ro;
        regAddr <= a;
        @(posedge sys_clk);
        regValid <= 1'b0;
        #1;
        chk("regGrant", regGrant_q, ok);
        chk("regDeny", regDeny_q, !ok);
    endtask

    task automatic test_regs();
        reg_case(3'h0, 3'h0, 1'b1, 1'b0, 21'h002600, 1'b1);
        reg_case(3'h0, 3'h0, 1'b1, 1'b0, 21'h00267c, 1'b1);
        reg_case(3'h0, 3'h0, 1'b1, 1'b0, 21'h002680, 1'b0);
        reg_case(3'h0, 3'h0, 1'b0, 1'b1, 21'h002680, 1'b1);
        reg_case(3'h0, 3'h0, 1'b1, 1'b1, 21'h002680, 1'b0);
        reg_case(3'h0, 3'h0, 1'b0, 1'b0, 21'h002600, 1'b1);
        reg_case(3'h1, 3'h0, 1'b1, 1'b0, 21'h018320, 1'b1);
        reg_case(3'h1, 3'h0, 1'b1, 1'b0, 21'h002600, 1'b0);
        reg_case(3'h2, 3'h0, 1'b1, 1'b0, 21'h01a67c, 1'b1);
        reg_case(3'h5, 3'h1, 1'b1, 1'b0, 21'h1d8600, 1'b1);
        reg_case(3'h5, 3'h1, 1'b1, 1'b0, 21'h1d8680, 1'b0);
        reg_case(3'h4, 3'h2, 1'b1, 1'b0, 21'h1d0ffc, 1'b1);
        reg_case(3'h4, 3'h2, 1'b1, 1'b0, 21'h1d1000, 1'b0);
        reg_case(3'h4, 3'h2, 1'b1, 1'b0, 21'h1d28fc, 1'b1);
        reg_case(3'h4, 3'h1, 1'b1, 1'b0, 21'h004290, 1'b1);
        reg_case(3'h4, 3'h2, 1'b1, 1'b0, 21'h004290, 1'b0);
    endtask

    task automatic test_ctx(input logic s);
        @(posedge sys_clk);
        slow <= s;
        ctxSubmitValid <= 1'b1;
        ctxDescAddr <= 32'h00ab_cd00;
        @(posedge sys_clk);
        ctxSubmitValid <= 1'b0;
        #1;
        chk("ctxLoadReq", ctxLoadReq_q, 32'h1);
        chk("ctxLoadAddr", ctxLoadAddr_q, 32'h00ab_cd00);
        for (int n = 0; n < 20 && ctxRunning_q !== 1'b1; n++)
            @(negedge sys_clk);
        chk("ctxRunning", ctxRunning_q, 32'h1);
        @(posedge sys_clk);
        ctxSubmitValid <= 1'b1;
        ctxDescAddr <= 32'h0000_1000;
        @(posedge sys_clk);
        ctxSubmitValid <= 1'b0;
        ctxDone <= 1'b1;
        @(posedge sys_clk);
        ctxDone <= 1'b0;
        #1;
        chk("ctxReady", ctxReady_q, 32'h1);
        chk("ctxLoadReq", ctxLoadReq_q, 32'h0);
        chk("ctxLoadAddr", ctxLoadAddr_q, 32'h00ab_cd00);
    endtask

    task automatic test_power();
        for (int i = 0; i < 17; i++)
        begin
            @(posedge sys_clk);
            gsWrValid <= i < 16;
            gsWrIdx <= i[3:0];
            gsWrData <= 32'h5a00_0000 + i;
        end
        pwrDownReq <= 1'b1;
        @(posedge sys_clk);
        pwrDownReq <= 1'b0;
        // A write while saving must not reach the shared copy.
        gsWrValid <= 1'b1;
        gsWrIdx <= 4'hf;
        gsWrData <= 32'hdead_beef;
        @(posedge sys_clk);
        gsWrValid <= 1'b0;
        for (int n = 0; n < 8 && saveValid_q !== 1'b1; n++)
            @(negedge sys_clk);
        for (int i = 0; i < 16; i++)
        begin
            chk("saveValid", saveValid_q, 32'h1);
            chk("saveIdx", saveIdx_q, i);
            chk("saveData", saveData, 32'h5a00_0000 + i);
            @(negedge sys_clk);
        end
        chk("pwrOff", pwrOff_q, 32'h1);
        // Power-off loses the shared copy, so only the restore can refill it.
        for (int j = 0; j < 16; j++)
            u_nonpriv_batch_register_gate.u_state.mem[j] = 32'h0;
        @(posedge sys_clk);
        pwrUpReq <= 1'b1;
        @(posedge sys_clk);
        pwrUpReq <= 1'b0;
        #1;
        chk("restoreReq", restoreReq_q, 32'h1);
        for (int n = 0; n < 60 && pwrOff_q !== 1'b0; n++)
            @(negedge sys_clk);
        chk("pwrOff", pwrOff_q, 32'h0);
        chk("restoreReq", restoreReq_q, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge sys_clk);
            gsRdIdx <= i[3:0];
            @(negedge sys_clk);
            @(negedge sys_clk);
            chk("gsRdData", gsRdData, 32'h5a00_0000 + i);
        end
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        test_cmds();
        test_regs();
        test_ctx(1'b0);
        test_ctx(1'b1);
        test_power();
        give_verdict();
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict();
        end
    end
endmodule
bind nonpriv_batch_register_gate nonpriv_gate_properties u_nonpriv_gate_properties (.*);
`default_nettype wire
